//--- rtl/afe_add_exec.sv
// add family decode and execute unit behind an axi4-lite register file
//
// Notes on behaviour
// - four-bit condition field tested against flags
// - decimal add byte with extend
// - decimal flags: carry, extend, sticky zero
// - mode bit picks registers or predecrement memory
// - decimal add word layout decoded
// - add opmode gives size and direction
// - binary add sets n z v c x
// - source addressing modes decoded
// - add to ea needs memory alterable
// - address add full width, flags kept
// - address add word source sign-extended
// - immediate taken from extension words by size
// - add immediate needs data alterable
// - add quick adds one to eight
// - quick to address register, word/long
// - byte, word and long sizes
// - quick field zero means eight
//
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
module afe_add_exec (
   input wire logic aclk, // core clock
   input wire logic aresetn, // sync reset, active low
   input wire logic awvalid, // write address valid
   output logic awready, // write address ready
   input wire logic [afe_pkg::ADDR_W-1:0] awaddr, // write address
   input wire logic [2:0] awprot, // unused protection
   input wire logic wvalid, // write data valid
   output logic wready, // write data ready
   input wire logic [31:0] wdata, // write data
   input wire logic [3:0] wstrb, // byte enables
   output logic bvalid, // write response valid
   input wire logic bready, // write response ready
   output logic [1:0] bresp, // write response
   input wire logic arvalid, // read address valid
   output logic arready, // read address ready
   input wire logic [afe_pkg::ADDR_W-1:0] araddr, // read address
   input wire logic [2:0] arprot, // unused protection
   output logic rvalid, // read data valid
   input wire logic rready, // read data ready
   output logic [31:0] rdata, // read data
   output logic [1:0] rresp // read response
);
   import afe_pkg::*;
   afe_state_t state_reg;
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic [15:0] opword_reg;
   logic [31:0] ext_reg;
   logic [31:0] src_reg;
   logic [31:0] dst_reg;
   logic [4:0] ccr_reg;
   logic [3:0] cond_reg;
   logic [31:0] result_reg;
   logic [15:0] status_reg;

   function automatic logic [31:0] afe_merge(input logic [31:0] old_v,
         input logic [31:0] new_v, input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction : afe_merge
   // waits for address and data together, which covers either order
   wire wr_take = awvalid && wvalid && !awready_reg && !bvalid_reg;
   wire wr_fire = awready_reg && wready_reg;
   wire rd_take = arvalid && !arready_reg && !rvalid_reg;
   wire wr_hit = awaddr == REG_CTRL || awaddr == REG_OPWORD ||
                 awaddr == REG_EXT || awaddr == REG_SRC ||
                 awaddr == REG_DST || awaddr == REG_CCR ||
                 awaddr == REG_COND;
   wire [31:0] wd_merged_ext = afe_merge(ext_reg, wdata, wstrb);
   wire [31:0] wd_merged_src = afe_merge(src_reg, wdata, wstrb);
   wire [31:0] wd_merged_dst = afe_merge(dst_reg, wdata, wstrb);
   wire [31:0] wd_merged_op = afe_merge({16'h0, opword_reg}, wdata, wstrb);
   wire wr_op = wr_fire && awaddr == REG_OPWORD;
   wire wr_ccr = wr_fire && awaddr == REG_CCR && wstrb[0];
   wire wr_cond = wr_fire && awaddr == REG_COND && wstrb[0];
   wire start = wr_fire && awaddr == REG_CTRL && wstrb[0] &&
                wdata[CTRL_START] && state_reg == AFE_IDLE;
   logic [31:0] rd_word;
   logic rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      case (araddr)
         REG_CTRL: rd_word = {31'h0, state_reg == AFE_EXEC};
         REG_OPWORD: rd_word = {16'h0, opword_reg};
         REG_EXT: rd_word = ext_reg;
         REG_SRC: rd_word = src_reg;
         REG_DST: rd_word = dst_reg;
         REG_CCR: rd_word = {27'h0, ccr_reg};
         REG_COND: rd_word = {28'h0, cond_reg};
         REG_RESULT: rd_word = result_reg;
         REG_STATUS: rd_word = {16'h0, status_reg};
         default: begin
            rd_word = 32'h0;
            rd_hit = 1'b0;
         end
      endcase
   end
   wire [2:0] ea_mode = opword_reg[5:3];
   wire [2:0] ea_rg = opword_reg[2:0];
   wire [2:0] opmode = opword_reg[8:6];
   wire [1:0] sz_fld = opword_reg[7:6];
   wire is_dec = opword_reg[15:12] == OP_DEC_TOP &&
                 opword_reg[8:4] == OP_DEC_MID;
   // mode bit chooses predecrement memory form
   wire dec_mem = opword_reg[3];
   wire is_add_grp = opword_reg[15:12] == OP_ADD_TOP;
   wire is_addr = is_add_grp && opmode[1:0] == 2'h3;
   // low opmode bits size, bit 2 direction
   wire is_add = is_add_grp && opmode[1:0] != 2'h3;
   wire add_to_ea = opmode[2];
   wire is_imm = opword_reg[15:8] == OP_IMM_TOP;
   wire is_quick = opword_reg[15:12] == OP_QUICK_TOP && !opword_reg[8];
   wire ea_src_ok = ea_mode != EA_EXT || ea_rg <= EA_X_IMM;
   wire ea_is_an = ea_mode == EA_AN;
   wire ea_mem_alt = (ea_mode >= EA_IND && ea_mode <= EA_IDX) ||
                     (ea_mode == EA_EXT && ea_rg <= EA_X_ABSL);
   wire ea_data_alt = ea_mode == EA_DN || ea_mem_alt;
   // one size code for all forms
   logic [1:0] op_size;
   always_comb begin
      if (is_dec) begin
         op_size = SZ_B;
      end else if (is_addr) begin
         op_size = opmode[2] ? SZ_L : SZ_W;
      end else if (is_add) begin
         op_size = opmode[1:0];
      end else begin
         op_size = sz_fld;
      end
   end

   logic legal;
   always_comb begin
      legal = 1'b0;
      if (is_dec) begin
         legal = 1'b1;
      end else if (is_addr) begin
         legal = ea_src_ok;
      end else if (is_add && add_to_ea) begin
         legal = ea_mem_alt;
      end else if (is_add) begin
         legal = ea_src_ok && !(ea_is_an && op_size == SZ_B);
      end else if (is_imm) begin
         legal = ea_data_alt && op_size != SZ_BAD;
      end else if (is_quick) begin
         // address register only for word or long
         legal = op_size != SZ_BAD &&
                 (ea_data_alt || (ea_is_an && op_size != SZ_B));
      end
   end

   wire [2:0] kind = is_dec ? K_DEC : is_addr ? K_ADDR :
                     is_add ? K_ADD : is_imm ? K_IMM :
                     is_quick ? K_QUICK : K_NONE;
   // immediate out of extension words, first word high
   wire [31:0] imm_val = op_size == SZ_B ? {24'h0, ext_reg[23:16]} :
                         op_size == SZ_W ? {16'h0, ext_reg[31:16]} :
                         ext_reg;
   wire [3:0] quick_val = opword_reg[11:9] == 3'h0 ? 4'h8 :
                          {1'b0, opword_reg[11:9]};
   wire [31:0] opa = is_imm ? imm_val :
                     is_quick ? {28'h0, quick_val} : src_reg;
   wire [31:0] opa_addr = (is_addr && op_size == SZ_W) ?
                          {{16{src_reg[15]}}, src_reg[15:0]} : opa;
   wire addr_path = is_addr || (is_quick && ea_is_an);
   wire [8:0] s8 = {1'b0, opa[7:0]} + {1'b0, dst_reg[7:0]};
   wire [16:0] s16 = {1'b0, opa[15:0]} + {1'b0, dst_reg[15:0]};
   wire [32:0] s32 = {1'b0, opa} + {1'b0, dst_reg};
   wire [31:0] addr_sum = opa_addr + dst_reg;
   // byte and word results keep the upper destination bits
   wire [31:0] bin_res = op_size == SZ_B ? {dst_reg[31:8], s8[7:0]} :
                         op_size == SZ_W ? {dst_reg[31:16], s16[15:0]} :
                         s32[31:0];
   wire bin_c = op_size == SZ_B ? s8[8] :
                op_size == SZ_W ? s16[16] : s32[32];
   wire a_msb = op_size == SZ_B ? opa[7] :
                op_size == SZ_W ? opa[15] : opa[31];
   wire d_msb = op_size == SZ_B ? dst_reg[7] :
                op_size == SZ_W ? dst_reg[15] : dst_reg[31];
   wire r_msb = op_size == SZ_B ? bin_res[7] :
                op_size == SZ_W ? bin_res[15] : bin_res[31];
   wire r_zero = op_size == SZ_B ? bin_res[7:0] == 8'h0 :
                 op_size == SZ_W ? bin_res[15:0] == 16'h0 :
                 bin_res == 32'h0;
   wire bin_v = (a_msb == d_msb) && (r_msb != a_msb);

   wire cond_true;
   wire [7:0] bcd_sum;
   wire bcd_carry;
   afe_cond_bcd i_afe_cond_bcd (
      .cond(cond_reg),
      .ccr(ccr_reg),
      .bcd_a(src_reg[7:0]),
      .bcd_b(dst_reg[7:0]),
      .bcd_x(ccr_reg[CCR_X]),
      .cond_true(cond_true),
      .bcd_sum(bcd_sum),
      .bcd_carry(bcd_carry)
   );
   logic [31:0] res_next;
   logic [4:0] ccr_next;
   always_comb begin
      res_next = result_reg;
      ccr_next = ccr_reg;
      if (!legal) begin
         // nothing executes on an illegal encoding
         res_next = result_reg;
      end else if (is_dec) begin
         res_next = {dst_reg[31:8], bcd_sum};
         // carry and extend from decimal carry
         ccr_next[CCR_C] = bcd_carry;
         ccr_next[CCR_X] = bcd_carry;
         // zero only ever cleared; n and v left as they were
         if (bcd_sum != 8'h0) begin
            ccr_next[CCR_Z] = 1'b0;
         end
      end else if (addr_path) begin
         res_next = addr_sum;
      end else begin
         res_next = bin_res;
         ccr_next[CCR_N] = r_msb;
         ccr_next[CCR_Z] = r_zero;
         ccr_next[CCR_V] = bin_v;
         ccr_next[CCR_C] = bin_c;
         ccr_next[CCR_X] = bin_c;
      end
   end

   wire dest_ea = (is_add && add_to_ea) ||
                  ((is_imm || is_quick) && ea_mode != EA_DN && !ea_is_an) ||
                  (is_dec && dec_mem);
   wire [15:0] status_next = {1'b0, kind, 2'h0, op_size, 2'h0,
                              addr_path, dest_ea, cond_reg == 4'h1,
                              cond_true, !legal, 1'b1};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= AFE_IDLE;
      end else if (start) begin
         state_reg <= AFE_EXEC;
      end else begin
         state_reg <= AFE_IDLE;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         result_reg <= WORD_RST;
         status_reg <= 16'h0;
      end else if (state_reg == AFE_EXEC) begin
         result_reg <= res_next;
         status_reg <= status_next;
      end else if (start) begin
         // done drops while a new operation runs
         status_reg[ST_DONE] <= 1'b0;
      end
   end

   // flags follow an execution, else a software write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ccr_reg <= CCR_RST;
      end else if (state_reg == AFE_EXEC) begin
         ccr_reg <= ccr_next;
      end else if (wr_ccr) begin
         ccr_reg <= wdata[4:0];
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         opword_reg <= 16'h0;
         ext_reg <= WORD_RST;
         src_reg <= WORD_RST;
         dst_reg <= WORD_RST;
         cond_reg <= COND_RST;
      end else begin
         if (wr_op) begin
            opword_reg <= wd_merged_op[15:0];
         end
         if (wr_fire && awaddr == REG_EXT) begin
            ext_reg <= wd_merged_ext;
         end
         if (wr_fire && awaddr == REG_SRC) begin
            src_reg <= wd_merged_src;
         end
         if (wr_fire && awaddr == REG_DST) begin
            dst_reg <= wd_merged_dst;
         end
         if (wr_cond) begin
            cond_reg <= wdata[3:0];
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else begin
         awready_reg <= wr_take;
         wready_reg <= wr_take;
         if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= WORD_RST;
         rresp_reg <= RESP_OKAY;
      end else begin
         arready_reg <= rd_take;
         if (arready_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   assign awready = awready_reg;
   assign wready = wready_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign arready = arready_reg;
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;
endmodule : afe_add_exec

//--- rtl/afe_cond_bcd.sv
// condition test evaluator and packed decimal byte adder
`timescale 1ns/1ps
module afe_cond_bcd (
   input wire logic [3:0] cond, // condition field
   input wire logic [4:0] ccr, // flags x n z v c
   input wire logic [7:0] bcd_a, // decimal source byte
   input wire logic [7:0] bcd_b, // decimal destination byte
   input wire logic bcd_x, // extend carry in
   output logic cond_true, // condition holds
   output logic [7:0] bcd_sum, // decimal sum
   output logic bcd_carry // decimal carry out
);
   import afe_pkg::*;
   wire n = ccr[CCR_N];
   wire z = ccr[CCR_Z];
   wire v = ccr[CCR_V];
   wire c = ccr[CCR_C];
   wire [4:0] lo_raw;
   wire lo_adj;
   wire [4:0] lo_fix;
   wire [4:0] up_raw;
   wire up_adj;
   wire [4:0] up_fix;
   always_comb begin
      case (cond)
         4'h0: cond_true = 1'b1;
         4'h1: cond_true = 1'b0;
         4'h2: cond_true = !c && !z;
         4'h3: cond_true = c || z;
         4'h4: cond_true = !c;
         4'h5: cond_true = c;
         4'h6: cond_true = !z;
         4'h7: cond_true = z;
         4'h8: cond_true = !v;
         4'h9: cond_true = v;
         4'ha: cond_true = !n;
         4'hb: cond_true = n;
         4'hc: cond_true = n == v;
         4'hd: cond_true = n != v;
         4'he: cond_true = !z && (n == v);
         default: cond_true = z || (n != v);
      endcase
   end
   assign lo_raw = {1'b0, bcd_a[3:0]} + {1'b0, bcd_b[3:0]} + {4'h0, bcd_x};
   assign lo_adj = lo_raw > 5'h09;
   assign lo_fix = lo_adj ? lo_raw + 5'h06 : lo_raw;
   assign up_raw = {1'b0, bcd_a[7:4]} + {1'b0, bcd_b[7:4]} + {4'h0, lo_adj};
   assign up_adj = up_raw > 5'h09;
   assign up_fix = up_adj ? up_raw + 5'h06 : up_raw;
   assign bcd_sum = {up_fix[3:0], lo_fix[3:0]};
   assign bcd_carry = up_adj;
endmodule : afe_cond_bcd

//--- rtl/afe_pkg.sv
// constants for the add family execute block and its register map
package afe_pkg;
   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_OPWORD = 8'h04;
   localparam logic [7:0] REG_EXT = 8'h08;
   localparam logic [7:0] REG_SRC = 8'h0c;
   localparam logic [7:0] REG_DST = 8'h10;
   localparam logic [7:0] REG_CCR = 8'h14;
   localparam logic [7:0] REG_COND = 8'h18;
   localparam logic [7:0] REG_RESULT = 8'h1c;
   localparam logic [7:0] REG_STATUS = 8'h20;
   // control and status field positions
   localparam int CTRL_START = 0;
   localparam int ST_DONE = 0;
   localparam int ST_ILLEGAL = 1;
   localparam int ST_COND_TRUE = 2;
   localparam int ST_COND_NOBR = 3;
   localparam int ST_DEST_EA = 4;
   localparam int ST_DEST_AN = 5;
   localparam int ST_SIZE_LO = 8;
   localparam int ST_KIND_LO = 12;
   // condition code bit positions
   localparam int CCR_X = 4;
   localparam int CCR_N = 3;
   localparam int CCR_Z = 2;
   localparam int CCR_V = 1;
   localparam int CCR_C = 0;
   // reset values
   localparam logic [4:0] CCR_RST = 5'h00;
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
   localparam logic [3:0] COND_RST = 4'h0;
   // operand sizes
   localparam logic [1:0] SZ_B = 2'h0;
   localparam logic [1:0] SZ_W = 2'h1;
   localparam logic [1:0] SZ_L = 2'h2;
   localparam logic [1:0] SZ_BAD = 2'h3;
   // instruction kinds reported in status
   localparam logic [2:0] K_NONE = 3'h0;
   localparam logic [2:0] K_DEC = 3'h1;
   localparam logic [2:0] K_ADD = 3'h2;
   localparam logic [2:0] K_ADDR = 3'h3;
   localparam logic [2:0] K_IMM = 3'h4;
   localparam logic [2:0] K_QUICK = 3'h5;
   // opcode patterns
   localparam logic [3:0] OP_DEC_TOP = 4'hc;
   localparam logic [4:0] OP_DEC_MID = 5'h10;
   localparam logic [3:0] OP_ADD_TOP = 4'hd;
   localparam logic [7:0] OP_IMM_TOP = 8'h06;
   localparam logic [3:0] OP_QUICK_TOP = 4'h5;
   // effective address modes
   localparam logic [2:0] EA_DN = 3'h0;
   localparam logic [2:0] EA_AN = 3'h1;
   localparam logic [2:0] EA_IND = 3'h2;
   localparam logic [2:0] EA_IDX = 3'h6;
   localparam logic [2:0] EA_EXT = 3'h7;
   localparam logic [2:0] EA_X_ABSL = 3'h1;
   localparam logic [2:0] EA_X_IMM = 3'h4;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int ADDR_W = 8;
   typedef enum logic [0:0] {AFE_IDLE, AFE_EXEC} afe_state_t;
endpackage : afe_pkg

//--- tb/afe_add_exec_props.sv
// bus handshake checker for the add family execute block
`timescale 1ns/1ps
module afe_add_exec_props (
   input wire logic aclk, // core clock
   input wire logic aresetn, // sync reset, active low
   input wire logic awvalid, // write address valid
   input wire logic awready, // write address ready
   input wire logic wvalid, // write data valid
   input wire logic wready, // write data ready
   input wire logic bvalid, // write response valid
   input wire logic bready, // write response ready
   input wire logic [1:0] bresp, // write response
   input wire logic arvalid, // read address valid
   input wire logic arready, // read address ready
   input wire logic rvalid, // read data valid
   input wire logic rready, // read data ready
   input wire logic [31:0] rdata, // read data
   input wire logic [1:0] rresp // read response
);
   import afe_pkg::*;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_aw_w_pair: assert property (awready |-> wready && !bvalid)
      else $error("address and data ready apart");
   a_aw_pulse: assert property (awready |=> !awready && !wready && bvalid)
      else $error("write ready not a pulse before response");
   a_aw_cause: assert property (awready |-> $past(awvalid) && $past(wvalid))
      else $error("write taken without request");
   a_aw_take: assert property
      (awvalid && wvalid && !awready && !bvalid |-> ##[1:2] awready)
      else $error("write request not taken");
   a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped early");
   a_b_drop: assert property (bvalid && bready |=> !bvalid)
      else $error("write response stuck");
   a_ar_pulse: assert property (arready |=> !arready && rvalid)
      else $error("read ready not followed by data");
   a_ar_cause: assert property (arready |-> $past(arvalid) && !rvalid)
      else $error("read taken without request");
   a_r_hold: assert property
      (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read data changed while waiting");
   a_r_drop: assert property (rvalid && rready |=> !rvalid)
      else $error("read data stuck");
   a_rerr_zero: assert property
      (rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0)
      else $error("error read carries data");
   c_write: cover property (bvalid && bready && bresp == RESP_OKAY);
   c_wr_err: cover property (bvalid && bresp == RESP_SLVERR);
   c_rd_err: cover property (rvalid && rresp == RESP_SLVERR);
endmodule : afe_add_exec_props

//--- tb/afe_add_exec_tb_top.sv
// self-checking bench for the add family execute block
`timescale 1ns/1ps
module afe_add_exec_tb_top;
   import afe_pkg::*;
   typedef struct {logic [33:0] e; logic [33:0] m;} afe_note_t;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, sel;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, a, d, e, x, last;
   logic [15:0] op;
   logic [3:0] wstrb, c;
   logic [1:0] bresp, rresp, sz;
   logic [4:0] f, cf;
   logic [8:0] b;
   int fail_count, cmp_count;
   afe_note_t wq[$], rq[$];
   logic [15:0] bad [10] = '{16'hd100, 16'hd148, 16'hd1bc, 16'hd13a,
      16'hd008, 16'h0648, 16'h067a, 16'h06c0, 16'h5008, 16'h503c};

   afe_add_exec i_afe_add_exec (
      .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
      .rresp(rresp)
   );

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   function automatic logic cnd(input logic [3:0] k, input logic [4:0] g);
      logic n, z, v, y, t;
      {n, z, v, y} = g[3:0];
      case (k[3:1])
         3'h0: t = 1'b1;
         3'h1: t = !y && !z;
         3'h2: t = !y;
         3'h3: t = !z;
         3'h4: t = !v;
         3'h5: t = !n;
         3'h6: t = n == v;
         default: t = n == v && !z;
      endcase
      // odd codes are the complement of the even ones
      return t ^ k[0];
   endfunction : cnd

   function automatic logic [36:0] addv(input logic [1:0] s,
         input logic [31:0] p, q);
      logic [31:0] m, r;
      logic [32:0] t;
      int w;
      w = 8 << s;
      m = (32'h1 << w) - 32'h1;
      t = {1'b0, p & m} + {1'b0, q & m};
      r = (q & ~m) | (t[31:0] & m);
      return {t[w], t[w-1], (t[31:0] & m) == 32'h0,
         p[w-1] == q[w-1] && t[w-1] != q[w-1], t[w], r};
   endfunction : addv

   function automatic logic [8:0] bcd(input logic [7:0] p, q,
         input logic y);
      logic [4:0] lo, up;
      lo = p[3:0] + q[3:0] + y;
      if (lo > 5'd9) lo = lo + 5'd6;
      up = p[7:4] + q[7:4] + lo[4];
      if (up > 5'd9) up = up + 5'd6;
      return {up[4], up[3:0], lo[3:0]};
   endfunction : bcd

   function automatic logic [7:0] rb();
      return {4'($urandom % 10), 4'($urandom % 10)};
   endfunction : rb

   function automatic logic [31:0] stw(input logic [2:0] k,
         input logic [1:0] s, input logic ea, ad);
      return {17'h0, k, 2'h0, s, 2'h0, ad, ea, c == 4'h1, cnd(c, f), 2'h1};
   endfunction : stw

   task automatic chk(input string nm, input logic [33:0] s,
         input afe_note_t n);
      cmp_count++;
      if ((s & n.m) !== (n.e & n.m)) begin
         fail_count++;
         $display("unexpected %s exp %h seen %h", nm, n.e, s);
      end
   endtask : chk

   task automatic wr(input logic [7:0] ad, input logic [31:0] v,
         input logic [1:0] er = RESP_OKAY);
      wq.push_back('{{32'h0, er}, '1});
      awaddr <= ad;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // one idle edge after the response keeps writes spaced apart
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) bready <= 1'b0;
      end while (awvalid || wvalid || bready);
   endtask : wr

   task automatic rd(input logic [7:0] ad, input logic [31:0] v, m,
         input logic [1:0] er = RESP_OKAY);
      rq.push_back('{{er, v}, {2'h3, m}});
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) rready <= 1'b0;
      end while (arvalid || rready);
   endtask : rd

   task automatic rnd();
      a = $urandom;
      d = $urandom;
      f = 5'($urandom);
      c = 4'($urandom);
   endtask : rnd

   task automatic run(input logic [31:0] ext, input logic [36:0] ex,
         input logic [31:0] st, sm);
      wr(REG_OPWORD, {16'h0, op});
      wr(REG_EXT, ext);
      wr(REG_SRC, a);
      wr(REG_DST, d);
      wr(REG_CCR, {27'h0, f});
      wr(REG_COND, {28'h0, c});
      wr(REG_CTRL, 32'h1);
      rd(REG_RESULT, ex[31:0], '1);
      rd(REG_CCR, {27'h0, ex[36:32]}, '1);
      rd(REG_STATUS, st, sm);
      last = ex[31:0];
   endtask : run

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up

   always @(posedge aclk) begin
      if (bvalid && bready) chk("bresp", {32'h0, bresp}, wq.pop_front());
      if (rvalid && rready) chk("rdata", {rresp, rdata}, rq.pop_front());
   end

   initial begin
      repeat (20000) @(posedge aclk);
      fail_count++;
      $display("watchdog expired");
      wrap_up();
   end

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'hf;
      last = '0;
      void'($urandom(84));
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(REG_STATUS, 32'h0, '1);
      rd(REG_CCR, 32'h0, '1);
      rd(REG_COND, 32'h0, '1);
      rd(REG_RESULT, 32'h0, '1);
      rd(8'h24, 32'h0, '1, RESP_SLVERR);
      wr(8'h24, 32'h1, RESP_SLVERR);
      wr(REG_STATUS, 32'h1, RESP_SLVERR);
      wr(REG_COND, 32'h9);
      // partial strobes: cond needs byte 0, src merges bytes
      wstrb <= 4'ha;
      wr(REG_COND, 32'h3);
      wr(REG_SRC, 32'h1122_3344);
      wstrb <= 4'hf;
      rd(REG_COND, 32'h9, '1);
      rd(REG_SRC, 32'h1100_3300, '1);
      rd(REG_CTRL, 32'h0, '1);
      $display("test registers done");
      for (int i = 0; i < 32; i++) begin
         rnd();
         c = 4'(i);
         sel = i[4];
         e = sel ? {{16{a[15]}}, a[15:0]} : a;
         op = {4'hd, 3'h1, !sel, 2'h3, 3'($urandom_range(6)), 3'h4};
         run(32'h0, {f, d + e},
            stw(K_ADDR, sel ? SZ_W : SZ_L, 1'b0, 1'b1), '1);
      end
      $display("test address add done");
      for (int i = 0; i < 12; i++) begin
         rnd();
         sz = 2'(i % 3);
         sel = 1'((i / 3) % 2);
         if (i == 0) begin
            a = 32'h80;
            d = 32'hffff_ff80;
         end
         op = {4'hd, 3'h6, sel, sz, 3'($urandom_range(6, 2)), 3'h1};
         run(32'h0, addv(sz, a, d),
            stw(K_ADD, sz, sel, 1'b0), '1);
      end
      $display("test add done");
      for (int i = 0; i < 6; i++) begin
         rnd();
         sz = 2'(i % 3);
         e = $urandom;
         sel = i > 2;
         x = sz == SZ_L ? e : sz == SZ_W ? e >> 16 : (e >> 16) & 32'hff;
         op = {8'h06, sz, sel ? 3'($urandom_range(6, 2)) : 3'h0, 3'h5};
         run(e, addv(sz, x, d),
            stw(K_IMM, sz, sel, 1'b0), '1);
      end
      $display("test add immediate done");
      for (int i = 0; i < 10; i++) begin
         rnd();
         sel = i > 7;
         sz = sel ? 2'(i - 7) : 2'(i % 3);
         x = i % 8 == 0 ? 32'h8 : 32'(i % 8);
         op = {4'h5, 3'(i), 1'b0, sz, 2'h0, sel, 3'h3};
         run(32'h0, sel ? {f, d + x} : addv(sz, x, d),
            stw(K_QUICK, sz, 1'b0, sel), '1);
      end
      $display("test add quick done");
      for (int i = 0; i < 8; i++) begin
         rnd();
         a = {24'h0, rb()};
         d[7:0] = rb();
         if (i == 0) begin
            a = 32'h0;
            d[7:0] = 8'h0;
            f = 5'h04;
         end
         if (i == 1) a = 32'h99;
         b = bcd(a[7:0], d[7:0], f[CCR_X]);
         cf = {b[8], f[3], f[2] && b[7:0] == 8'h0, f[1], b[8]};
         op = {4'hc, 3'h2, 5'h10, i[0], 3'h6};
         run(32'h0, {cf, d[31:8], b[7:0]},
            stw(K_DEC, SZ_B, i[0], 1'b0), '1);
      end
      $display("test decimal add done");
      for (int i = 0; i < 10; i++) begin
         rnd();
         op = bad[i];
         run(32'h0, {f, last}, 32'h3, 32'h3);
      end
      $display("test illegal modes done");
      wrap_up();
   end
endmodule : afe_add_exec_tb_top

bind afe_add_exec afe_add_exec_props i_afe_add_exec_props (
   .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
   .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
   .rready(rready), .rdata(rdata), .rresp(rresp)
);
